// [irq_seq.sv]
// interrupt entry and return sequencer for a small 8-bit core, with wishbone register access
// assumes one undivided core clock, pipeline reporting instruction boundaries and enable/disable instructions
// Function
// - core and sequencer run straight on the selected clock, no division.
// - each source has own vector; lower vector address served first.
// - reset ranks highest, external request zero directly below it.
// - source taken only when own enable and global enable are one.
// - accepting an interrupt clears the global enable bit.
// - global enable set inside handler lets enabled requests nest.
// - vectoring clears the request flag of flag-based sources.
// - writing one to a flag clears it; zero leaves it.
// - flag sets even when disabled and holds until serviced or cleared.
// - level sources request only while condition persists.
// - after return, one main-program instruction runs before next service.
// - status flags are neither saved on entry nor restored on return.
// - disable instruction acts at once, even against a simultaneous request.
// - after enable instruction, the next instruction runs before service.
// - entry takes four cycles pushing the program counter, then vector.
// - jump at vector takes three cycles to reach handler.
// - request during multi-cycle instruction waits for its completion.
// - waking from sleep adds four cycles to entry latency.
// - return takes four cycles, pops two bytes, sp plus two, sets enable.
// - entry push lowers stack pointer by two.
// - global enable sits at bit 7 of the status flags register.
`timescale 1ns/1ps
`include "irq_seq_map.svh"

module irq_seq (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [`NUM_SRC-1:0] src_evt_i,
  input wire logic [`NUM_SRC-1:0] src_lvl_i,
  input wire irq_seq_pkg::core_evt_t core_evt_i,
  output irq_seq_pkg::core_ctl_t core_ctl_o,
  output logic [`SP_W-1:0] sp_o,
  output logic gie_o,
  output logic [`SRC_W-1:0] irq_src_o,
  output logic busy_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  localparam logic [`CNT_W-1:0] ENTRY_N = `CNT_W'(`ENTRY_CYC);
  localparam logic [`CNT_W-1:0] WAKE_N = `CNT_W'(`WAKE_CYC);
  localparam logic [`CNT_W-1:0] JUMP_N = `CNT_W'(`JUMP_CYC);
  localparam logic [`CNT_W-1:0] RET_N = `CNT_W'(`RETURN_CYC);

  irq_seq_pkg::seq_state_t state_ff;
  irq_seq_pkg::seq_state_t nxt_state;
  logic [`CNT_W-1:0] cnt_ff;
  logic [`STAT_W-1:0] status_flags_reg_ff;
  logic [`NUM_SRC-1:0] enable_ff;
  logic [`NUM_SRC-1:0] flag_ff;
  logic [`NUM_SRC-1:0] level_mask_ff;
  logic [`SP_W-1:0] sp_ff;
  logic [`SRC_W-1:0] src_ff;
  logic hold_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;

  logic [`NUM_SRC-1:0] pend;
  logic [`NUM_SRC-1:0] flag_clr_sw;
  logic [`NUM_SRC-1:0] flag_clr_hw;
  logic any_pend;
  logic [`SRC_W-1:0] win;
  logic take;
  logic gie_now;
  logic wb_req;
  logic wb_wr;
  logic step;

  // ----------------------------------------------------------------
  // bus strobes
  // ----------------------------------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  assign step = ce_i;

  // ----------------------------------------------------------------
  // pending and priority
  // ----------------------------------------------------------------
  // level sources bypass the flag and vanish with their condition
  assign pend = enable_ff & ((flag_ff & ~level_mask_ff) | (src_lvl_i & level_mask_ff));

  // cli cuts the global enable in its own cycle
  assign gie_now = status_flags_reg_ff[`GIE_BIT] & ~core_evt_i.cli;

  always_comb begin
    win = '0;
    // descending scan: lowest index (lowest vector) wins
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win = `SRC_W'(i);
      end
    end
  end

  assign any_pend = |pend;

  // boundary only, not after sei or return, and not mid multi-cycle
  assign take = (state_ff == irq_seq_pkg::ST_RUN) & core_evt_i.boundary & ~core_evt_i.multi_busy
                & ~hold_ff & gie_now & any_pend;

  // ----------------------------------------------------------------
  // sequence state machine
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      irq_seq_pkg::ST_RUN: begin
        if (take) begin
          nxt_state = core_evt_i.sleeping ? irq_seq_pkg::ST_WAKE : irq_seq_pkg::ST_ENTRY;
        end else if (core_evt_i.return_from_irq & core_evt_i.boundary) begin
          nxt_state = irq_seq_pkg::ST_RET;
        end
      end
      irq_seq_pkg::ST_WAKE: begin
        if (cnt_ff == WAKE_N - 1'b1) begin
          nxt_state = irq_seq_pkg::ST_ENTRY;
        end
      end
      irq_seq_pkg::ST_ENTRY: begin
        if (cnt_ff == ENTRY_N - 1'b1) begin
          nxt_state = irq_seq_pkg::ST_JUMP;
        end
      end
      irq_seq_pkg::ST_JUMP: begin
        if (cnt_ff == JUMP_N - 1'b1) begin
          nxt_state = irq_seq_pkg::ST_RUN;
        end
      end
      irq_seq_pkg::ST_RET: begin
        if (cnt_ff == RET_N - 1'b1) begin
          nxt_state = irq_seq_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_state = irq_seq_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= irq_seq_pkg::ST_RUN;
    end else if (step) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= '0;
    end else if (step) begin
      if (nxt_state != state_ff) begin
        cnt_ff <= '0;
      end else if (state_ff != irq_seq_pkg::ST_RUN) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // one-instruction hold after return or sei
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_ff <= 1'b0;
    end else if (step) begin
      if ((state_ff == irq_seq_pkg::ST_RET) && (nxt_state == irq_seq_pkg::ST_RUN)) begin
        hold_ff <= 1'b1;
      end else if (core_evt_i.sei && core_evt_i.boundary && (state_ff == irq_seq_pkg::ST_RUN)) begin
        hold_ff <= 1'b1;
      end else if (core_evt_i.boundary && (state_ff == irq_seq_pkg::ST_RUN)) begin
        hold_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // source latch
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_ff <= '0;
    end else if (step && take) begin
      src_ff <= win;
    end
  end

  // ----------------------------------------------------------------
  // status flags: sequencer touches only the global enable; a bus write to REG_STATUS loads all bits
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_flags_reg_ff <= `STAT_RST;
    end else if (step) begin
      // no save or restore of other bits across entry/return
      if (take) begin
        status_flags_reg_ff[`GIE_BIT] <= 1'b0;
      end else if ((state_ff == irq_seq_pkg::ST_RET) && (cnt_ff == RET_N - 1'b1)) begin
        status_flags_reg_ff[`GIE_BIT] <= 1'b1;
      end else if (core_evt_i.cli) begin
        status_flags_reg_ff[`GIE_BIT] <= 1'b0;
      end else if (core_evt_i.sei) begin
        status_flags_reg_ff[`GIE_BIT] <= 1'b1;
      end else if (wb_wr && (wb_adr_i == `REG_STATUS)) begin
        status_flags_reg_ff <= wb_dat_i[`STAT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // request flags, one per source
  // ----------------------------------------------------------------
  assign flag_clr_sw = (wb_wr && (wb_adr_i == `REG_FLAGS)) ? wb_dat_i[`NUM_SRC-1:0] : '0;

  generate
    for (genvar g = 0; g < `NUM_SRC; g++) begin : g_flag
      assign flag_clr_hw[g] = take & (win == `SRC_W'(g)) & ~level_mask_ff[g];
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          flag_ff[g] <= 1'b0;
        end else if (step) begin
          if (src_evt_i[g]) begin
            flag_ff[g] <= 1'b1;
          end else if (flag_clr_hw[g] || flag_clr_sw[g]) begin
            flag_ff[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // enables, level mask
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_ff <= '0;
    end else if (step && wb_wr && (wb_adr_i == `REG_ENABLE)) begin
      enable_ff <= wb_dat_i[`NUM_SRC-1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_mask_ff <= `LEVEL_MASK_RST;
    end else if (step && wb_wr && (wb_adr_i == `REG_LEVEL)) begin
      level_mask_ff <= wb_dat_i[`NUM_SRC-1:0];
    end
  end

  // ----------------------------------------------------------------
  // stack pointer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp_ff <= `SP_RST;
    end else if (step) begin
      if ((state_ff == irq_seq_pkg::ST_ENTRY) && (cnt_ff == '0)) begin
        sp_ff <= sp_ff - `SP_STEP;
      end else if ((state_ff == irq_seq_pkg::ST_RET) && (cnt_ff == '0)) begin
        sp_ff <= sp_ff + `SP_STEP;
      end else if (wb_wr && (wb_adr_i == `REG_SP)) begin
        sp_ff <= wb_dat_i[`SP_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave: registered ack one cycle after the strobe, reads registered
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_ff <= 1'b0;
    end else if (step) begin
      ack_ff <= wb_req;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= 32'h00000000;
    end else if (step && wb_req) begin
      if (wb_adr_i == `REG_STATUS) begin
        rdata_ff <= {24'h000000, status_flags_reg_ff};
      end else if (wb_adr_i == `REG_ENABLE) begin
        rdata_ff <= {24'h000000, enable_ff};
      end else if (wb_adr_i == `REG_FLAGS) begin
        rdata_ff <= {24'h000000, flag_ff};
      end else if (wb_adr_i == `REG_LEVEL) begin
        rdata_ff <= {24'h000000, level_mask_ff};
      end else if (wb_adr_i == `REG_SP) begin
        rdata_ff <= {16'h0000, sp_ff};
      end else if (wb_adr_i == `REG_STATE) begin
        rdata_ff <= {24'h000000, src_ff, 2'b00, state_ff};
      end else begin
        rdata_ff <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign sp_o = sp_ff;
  assign gie_o = status_flags_reg_ff[`GIE_BIT];
  assign irq_src_o = src_ff;
  assign busy_o = (state_ff != irq_seq_pkg::ST_RUN);
  assign core_ctl_o.stall = (state_ff != irq_seq_pkg::ST_RUN) | take;
  assign core_ctl_o.push = (state_ff == irq_seq_pkg::ST_ENTRY);
  assign core_ctl_o.pop = (state_ff == irq_seq_pkg::ST_RET);
  assign core_ctl_o.load_pc = (state_ff == irq_seq_pkg::ST_JUMP) && (cnt_ff == '0);
  assign core_ctl_o.vector = `VEC_BASE + {{(`PC_W-`SRC_W){1'b0}}, src_ff};

endmodule // irq_seq

// [irq_seq_map.svh]
// constants for the interrupt sequencer: offsets, field positions, reset values, timing counts
// assumes inclusion by bare name from the package and the design file
`ifndef IRQ_SEQ_MAP_SVH
`define IRQ_SEQ_MAP_SVH

`define NUM_SRC 8
`define SRC_W 3
`define PC_W 12
`define SP_W 16
`define STAT_W 8
`define GIE_BIT 7
`define STAT_RST 8'h00
`define SP_RST 16'h0000
`define PC_RST 12'h000
`define VEC_BASE 12'h001
`define LEVEL_MASK_RST 8'h00
`define CLK_MHZ 50
`define ENTRY_NS 80
`define ENTRY_CYC ((`ENTRY_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_NS 80
`define WAKE_CYC ((`WAKE_NS * `CLK_MHZ + 999) / 1000)
`define RETURN_NS 80
`define RETURN_CYC ((`RETURN_NS * `CLK_MHZ + 999) / 1000)
`define JUMP_CYC 3
`define SP_STEP 16'h0002
`define CNT_W 4
// wishbone register offsets
`define REG_STATUS 8'h00
`define REG_ENABLE 8'h04
`define REG_FLAGS 8'h08
`define REG_LEVEL 8'h0C
`define REG_SP 8'h10
`define REG_STATE 8'h14

`endif

// [irq_seq_pkg.sv]
// types for the interrupt sequencer
// assumes irq_seq_map.svh is on the include path
`include "irq_seq_map.svh"

package irq_seq_pkg;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_WAKE  = 3'b001,
    ST_ENTRY = 3'b010,
    ST_JUMP  = 3'b011,
    ST_RET   = 3'b100
  } seq_state_t;

  // instruction-boundary report from the execution stage
  typedef struct packed {
    logic boundary;
    logic multi_busy;
    logic sei;
    logic cli;
    logic return_from_irq;
    logic sleeping;
  } core_evt_t;

  // entry and return control towards the execution stage
  typedef struct packed {
    logic stall;
    logic push;
    logic pop;
    logic load_pc;
    logic [`PC_W-1:0] vector;
  } core_ctl_t;

endpackage

// [irq_seq_checker.sv]
// timing checker for the interrupt sequencer, bound to its top module
// assumes one core clock and an asynchronous active-low reset
`timescale 1ns/1ps
`include "irq_seq_map.svh"

module irq_seq_checker (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire irq_seq_pkg::core_evt_t core_evt_i,
  input wire irq_seq_pkg::core_ctl_t core_ctl_o,
  input wire logic [`SP_W-1:0] sp_o,
  input wire logic gie_o,
  input wire logic [`SRC_W-1:0] irq_src_o,
  input wire logic busy_o
);
  logic push;
  logic pop;
  assign push = core_ctl_o.push;
  assign pop = core_ctl_o.pop;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------
  // entry, jump, return, hold, disable, long-instruction and wake sequences
  // ----------------------------------------
  a_entry_len: assert property ($rose(push) |-> push[*4] ##1 !push)
    else $error("entry push length wrong");
  a_entry_sp: assert property ($rose(push) |-> !gie_o ##4 sp_o == $past(sp_o, 5) - `SP_STEP)
    else $error("entry stack or enable wrong");
  a_vec_map: assert property (push |-> core_ctl_o.vector == {9'h000, irq_src_o} + `VEC_BASE)
    else $error("vector does not match source");
  a_jump_len: assert property ($rose(core_ctl_o.load_pc) |-> busy_o[*3] ##1 !busy_o)
    else $error("jump length wrong");
  a_ret_len: assert property ($rose(pop) |-> pop[*4] ##1 (!pop && gie_o && sp_o == $past(sp_o, 5) + `SP_STEP))
    else $error("return sequence wrong");
  a_ret_skip: assert property ($fell(pop) |=> !push)
    else $error("taken right after return");
  a_sei_skip: assert property (core_evt_i.sei && !busy_o |-> ##2 !push)
    else $error("taken right after enable");
  a_cli_block: assert property (core_evt_i.cli && !busy_o |=> !busy_o)
    else $error("taken with disable");
  a_multi_wait: assert property (core_evt_i.multi_busy && !busy_o |=> !busy_o)
    else $error("taken inside long instruction");
  a_wake_add: assert property ($rose(busy_o) && $past(core_evt_i.sleeping) |-> !push[*4] ##1 push)
    else $error("wake delay wrong");
endmodule // irq_seq_checker

bind irq_seq irq_seq_checker u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .core_evt_i(core_evt_i),
  .core_ctl_o(core_ctl_o), .sp_o(sp_o), .gie_o(gie_o), .irq_src_o(irq_src_o), .busy_o(busy_o));

// [irq_seq_core_model.sv]
// core pipeline model: boundaries, enable, disable, return, sleep and long instructions
// assumes op codes 1 enable, 2 disable, 3 return, 4 long, 5 sleep, held one cycle
`timescale 1ns/1ps

module irq_seq_core_model (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic busy_i,
  input wire irq_seq_pkg::core_ctl_t ctl_i,
  input wire logic [2:0] op_i,
  output irq_seq_pkg::core_evt_t evt_o
);
  logic [1:0] long_cnt_ff;
  logic sleep_ff;
  logic bnd;
  // stalled while the sequencer runs, no boundary inside a long instruction
  assign bnd = !busy_i && op_i != 3'h4 && long_cnt_ff == 2'h0;
  assign evt_o = {bnd, !busy_i && !bnd, bnd && op_i == 3'h1,
                  bnd && op_i == 3'h2, bnd && op_i == 3'h3, sleep_ff};
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i)
      long_cnt_ff <= 2'h0;
    else if (!busy_i && op_i == 3'h4)
      long_cnt_ff <= 2'h2;
    else if (long_cnt_ff != 2'h0)
      long_cnt_ff <= long_cnt_ff - 2'h1;
  end
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i)
      sleep_ff <= 1'b0;
    else if (ctl_i.load_pc)
      sleep_ff <= 1'b0;
    else if (bnd && op_i == 3'h5)
      sleep_ff <= 1'b1;
  end
endmodule // irq_seq_core_model

// [irq_seq_tb.sv]
// testbench for the interrupt sequencer: wishbone tasks and scenario sequence
// assumes the checker is bound to the design and the core model drives pipeline events
`timescale 1ns/1ps
`include "irq_seq_map.svh"

module irq_seq_tb;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_we = 1'b0;
  logic wb_ack, busy, gie;
  logic [7:0] wb_adr = 8'h00;
  logic [7:0] src_evt = 8'h00;
  logic [7:0] src_lvl = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic [31:0] q_sel;
  logic [3:0] wb_sel = 4'hF;
  logic ce = 1'b1;
  logic [2:0] op = 3'h0;
  logic [2:0] irq_src;
  logic [15:0] sp;
  irq_seq_pkg::core_evt_t evt;
  irq_seq_pkg::core_ctl_t ctl;
  int num_errors = 0;
  int check_count = 0;
  int cyc_cnt = 0;

  always #10 mclk_i = ~mclk_i;

  irq_seq DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce), .src_evt_i(src_evt), .src_lvl_i(src_lvl),
    .core_evt_i(evt), .core_ctl_o(ctl), .sp_o(sp), .gie_o(gie), .irq_src_o(irq_src), .busy_o(busy),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  irq_seq_core_model u_core (.mclk_i(mclk_i), .rstn_i(rstn_i), .busy_i(busy), .ctl_i(ctl), .op_i(op),
    .evt_o(evt));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic ins(input logic [2:0] o);
    op <= o;
    step(1);
    op <= 3'h0;
  endtask
  task automatic pulse(input logic [7:0] v);
    src_evt <= v;
    step(1);
    src_evt <= 8'h00;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_we <= we;
    wb_sel <= s;
    wb_adr <= a;
    wb_wdat <= d;
    do
      step(1);
    while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    step(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    chk(nm, q, exp);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      num_errors++;
      summarize();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    step(2);
    rstn_i <= 1'b1;
    step(1);
    rd(`REG_STATUS, 32'h0, "stat0");
    rd(`REG_SP, 32'h0, "sp0");
    rd(8'h40, 32'h0, "unmap");
    $display("test reset done");
    wr(`REG_SP, 32'h100);
    wr(`REG_ENABLE, 32'hFF);
    wr(`REG_LEVEL, 32'h10);
    pulse(8'h2A);
    step(1);
    chk("idle", 32'(busy), 32'h0);
    rd(`REG_FLAGS, 32'h2A, "flg");
    wr(`REG_FLAGS, 32'h0);
    rd(`REG_FLAGS, 32'h2A, "flgw0");
    wr(`REG_FLAGS, 32'h8);
    rd(`REG_FLAGS, 32'h22, "flgw1");
    $display("test flags done");
    wr(`REG_STATUS, 32'h5);
    ins(3'h1);
    step(14);
    chk("src", 32'(irq_src), 32'h1);
    chk("gie", 32'(gie), 32'h0);
    chk("sp", 32'(sp), 32'hFE);
    rd(`REG_FLAGS, 32'h20, "flgh");
    rd(`REG_STATUS, 32'h5, "stath");
    pulse(8'h01);
    ins(3'h1);
    step(14);
    chk("nest", 32'(irq_src), 32'h0);
    chk("spn", 32'(sp), 32'hFC);
    ins(3'h3);
    step(14);
    chk("after", 32'(irq_src), 32'h5);
    ins(3'h3);
    step(8);
    ins(3'h3);
    step(8);
    chk("spr", 32'(sp), 32'h100);
    chk("gier", 32'(gie), 32'h1);
    rd(`REG_STATUS, 32'h85, "statr");
    $display("test entry done");
    src_lvl <= 8'h10;
    ins(3'h2);
    step(4);
    chk("cli", 32'(busy), 32'h0);
    src_lvl <= 8'h00;
    step(2);
    ins(3'h1);
    step(6);
    chk("lvl0", 32'(busy), 32'h0);
    src_lvl <= 8'h10;
    ins(3'h4);
    step(14);
    chk("lvl1", 32'(irq_src), 32'h4);
    src_lvl <= 8'h00;
    ins(3'h3);
    step(8);
    $display("test level done");
    ins(3'h5);
    pulse(8'h40);
    step(18);
    chk("wake", 32'(irq_src), 32'h6);
    ins(3'h3);
    step(8);
    wr(`REG_ENABLE, 32'h7F);
    pulse(8'h80);
    step(4);
    chk("dis", 32'(busy), 32'h0);
    // enable low: an enabled event must neither latch nor start entry
    ce <= 1'b0;
    pulse(8'h01);
    step(3);
    chk("frz", 32'(busy), 32'h0);
    ce <= 1'b1;
    step(1);
    rd(`REG_FLAGS, 32'h80, "held");
    // write without the low byte lane selected is ignored
    wb(1'b1, `REG_ENABLE, 32'h0, 4'hE, q_sel);
    rd(`REG_ENABLE, 32'h7F, "sel0");
    $display("test enable done");
    summarize();
  end
endmodule // irq_seq_tb
